// ==== include/io_telemetry_pkg.sv ====
// shared constants for the io telemetry and copy engine
package io_telemetry_pkg;
  localparam int NUM_IO = 9;
  localparam int NUM_SLOTS = 9;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_PERIOD = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_SLOTS = 8'h10;
  localparam logic [7:0] OFS_EDGE_BASE = 8'h40;
  // field positions
  localparam int CTRL_ROLE_LSB = 0;
  localparam int CTRL_STANDBY_BIT = 2;
  localparam int ADDR_LOCAL_LSB = 0;
  localparam int ADDR_TEL_LSB = 8;
  localparam int ADDR_DATA_LSB = 16;
  // reset values
  localparam logic [1:0] ROLE_RST = 2'h0;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [15:0] PERIOD_RST = 16'h03e8;
  // io roles
  localparam logic [1:0] ROLE_NONE = 2'h0;
  localparam logic [1:0] ROLE_SERVER = 2'h1;
  localparam logic [1:0] ROLE_CLIENT = 2'h2;
  localparam logic [1:0] ROLE_TEL_CLIENT = 2'h3;
  // edge detector modes
  typedef enum logic [1:0] {
    EDGE_OFF = 2'b00, EDGE_RISE = 2'b01, EDGE_FALL = 2'b10, EDGE_BOTH = 2'b11
  } edge_mode_t;
  // frame bytes
  localparam logic [7:0] CH_SEP = 8'h54;
  localparam logic [7:0] CH_DIGITAL = 8'h44;
  localparam logic [7:0] CH_REPLY = 8'h52;
  localparam logic [7:0] CH_ERROR = 8'h45;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] ERR_ADDR = 8'hff;
  // wake-capable inputs
  localparam int WAKE_A_IDX = 2;
  localparam int WAKE_B_IDX = 3;
  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam logic [15:0] PERIOD_MIN_MS = 16'h0064;
  localparam logic [19:0] GRACE_MS = 20'h0_03e8;
endpackage : io_telemetry_pkg

// ==== logic/edge_detect.sv ====
// per-input edge detectors with wake gating
`timescale 1ns/100ps
module edge_detect #(
  parameter int N = 9
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // inputs and configuration
  input wire logic [N-1:0] pin_in,
  input wire logic [2*N-1:0] mode_cfg,
  input wire logic [N-1:0] allow,
  // result
  output logic edge_any
);
  logic [N-1:0] prev;
  logic [N-1:0] hit;

  // previous level of each input
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) prev <= '0;
    else prev <= pin_in;
  end

  // qualify each edge by its mode
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_in
      wire rise = pin_in[i] & ~prev[i];
      wire fall = ~pin_in[i] & prev[i];
      assign hit[i] = allow[i] & ((mode_cfg[2*i] & rise) | (mode_cfg[2*i+1] & fall));
    end
  endgenerate

  assign edge_any = |hit;
endmodule : edge_detect

// ==== logic/reply_framer.sv ====
// builds digital reply or error frames byte by byte
`timescale 1ns/100ps
module reply_framer (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // request
  input wire logic start,
  input wire logic is_err,
  input wire logic [7:0] addr,
  input wire logic [8:0] values,
  output logic busy,
  // byte stream
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data,
  output logic out_last
);
  typedef enum logic [2:0] {
    F_IDLE = 3'b000, F_ADDR = 3'b001, F_SEP = 3'b010, F_TECH = 3'b011,
    F_KIND = 3'b100, F_VHI = 3'b101, F_VLO = 3'b110, F_CR = 3'b111
  } fstate_t;
  fstate_t state, next_state;
  logic err;
  logic [7:0] a;
  logic [8:0] v;
  logic [7:0] next_data;

  // field sequence; error frames carry no value field
  always_comb begin
    next_state = state;
    unique case (state)
      F_IDLE: next_state = start ? F_ADDR : F_IDLE;
      F_ADDR: next_state = F_SEP;
      F_SEP: next_state = F_TECH;
      F_TECH: next_state = F_KIND;
      F_KIND: next_state = err ? F_CR : F_VHI;
      F_VHI: next_state = F_VLO;
      F_VLO: next_state = F_CR;
      F_CR: next_state = F_IDLE;
    endcase
  end

  // byte for the field being sent
  always_comb begin
    unique case (state)
      F_IDLE: next_data = 8'h00;
      F_ADDR: next_data = a;
      F_SEP: next_data = io_telemetry_pkg::CH_SEP;
      F_TECH: next_data = io_telemetry_pkg::CH_DIGITAL;
      F_KIND: next_data = err ? io_telemetry_pkg::CH_ERROR : io_telemetry_pkg::CH_REPLY;
      F_VHI: next_data = {7'h00, v[8]};
      F_VLO: next_data = v[7:0];
      F_CR: next_data = io_telemetry_pkg::CH_CR;
    endcase
  end

  assign busy = state != F_IDLE;
  assign out_valid = busy;
  assign out_data = next_data;
  assign out_last = state == F_CR;

  // latch the request, advance on each accepted byte
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= F_IDLE;
      err <= 1'b0;
      a <= 8'h00;
      v <= 9'h000;
    end else begin
      if (state == F_IDLE && start) begin
        err <= is_err;
        a <= addr;
        v <= values;
      end
      if (state == F_IDLE || out_ready) state <= next_state;
    end
  end
endmodule : reply_framer

// ==== logic/io_telemetry_copy_engine.sv ====
// edge telemetry, telemetry client, io copy and binding routing
`timescale 1ns/100ps
module io_telemetry_copy_engine #(
  parameter int MS_CYCLES = io_telemetry_pkg::MS_CYCLES,
  parameter int N = io_telemetry_pkg::NUM_IO,
  parameter int SLOTS = io_telemetry_pkg::NUM_SLOTS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // digital io
  input wire logic [N-1:0] io_in,
  output logic [N-1:0] io_out,
  // received copy frames
  input wire logic rx_valid,
  input wire logic [7:0] rx_src,
  input wire logic [7:0] rx_period_s,
  input wire logic [N-1:0] rx_values,
  // outgoing telemetry frame bytes
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic tx_last,
  output logic [7:0] tx_dest,
  output logic tx_local,
  output logic [7:0] tx_period_s,
  // serial link and power
  output logic ack_tx,
  output logic serial_orders_en,
  output logic [7:0] serial_data_dest,
  output logic standby
);
  typedef enum logic [1:0] {
    ST_RUN = 2'b00, ST_WAIT = 2'b01, ST_SLEEP = 2'b10
  } cstate_t;

  // lowest set bit of a slot vector
  function automatic logic [3:0] first_one(input logic [SLOTS-1:0] vec);
    logic [3:0] idx;
    idx = 4'hf;
    for (int k = SLOTS - 1; k >= 0; k--) begin
      if (vec[k]) idx = 4'(k);
    end
    return idx;
  endfunction : first_one

  // configuration
  logic [1:0] io_role_select;
  logic standby_policy;
  logic [7:0] local_module_addr;
  logic [7:0] telemetry_dest_addr;
  logic [7:0] data_dest_addr;
  logic [15:0] update_period_ms;
  logic [2*N-1:0] edge_cfg;
  // timers and control
  logic [31:0] ms_cnt;
  logic ms_tick;
  logic [15:0] per_cnt;
  logic [15:0] period_eff;
  logic period_due;
  cstate_t cstate;
  logic pend_tel;
  logic pend_reply;
  logic [7:0] reply_dest;
  logic [SLOTS-1:0] pend_err;
  // supervision slots
  logic [SLOTS-1:0] slot_used;
  logic [7:0] slot_addr [SLOTS];
  logic [7:0] slot_per [SLOTS];
  logic [19:0] slot_ms [SLOTS];
  logic [SLOTS-1:0] slot_match;
  logic [SLOTS-1:0] slot_expire;

  // role decode
  wire is_server = io_role_select == io_telemetry_pkg::ROLE_SERVER;
  wire is_client = io_role_select == io_telemetry_pkg::ROLE_CLIENT;
  wire is_tel_client = io_role_select == io_telemetry_pkg::ROLE_TEL_CLIENT;

  // apb decode
  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pwrite;
  wire hit_ctrl = paddr == io_telemetry_pkg::OFS_CTRL;
  wire hit_addr = paddr == io_telemetry_pkg::OFS_ADDR;
  wire hit_period = paddr == io_telemetry_pkg::OFS_PERIOD;
  wire hit_status = paddr == io_telemetry_pkg::OFS_STATUS;
  wire hit_slots = paddr == io_telemetry_pkg::OFS_SLOTS;
  wire [7:0] edge_ofs = paddr - io_telemetry_pkg::OFS_EDGE_BASE;
  wire [5:0] edge_idx = edge_ofs[7:2];
  wire hit_edge = paddr >= io_telemetry_pkg::OFS_EDGE_BASE && edge_ofs[1:0] == 2'b00
                  && edge_idx < 6'(N);
  wire mapped = hit_ctrl | hit_addr | hit_period | hit_status | hit_slots | hit_edge;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) rd_mux = {29'h0000_0000, standby_policy, io_role_select};
    if (hit_addr) rd_mux = {8'h00, data_dest_addr, telemetry_dest_addr, local_module_addr};
    if (hit_period) rd_mux = {16'h0000, update_period_ms};
    if (hit_status) rd_mux = {11'h000, cstate == ST_WAIT, tx_valid, standby, io_out, io_in};
    if (hit_slots) rd_mux = {7'h00, pend_err, 7'h00, slot_used};
    if (hit_edge) rd_mux = {30'h0000_0000, edge_cfg[2*edge_idx +: 2]};
  end

  // read data captured in the setup cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) prdata <= 32'h0000_0000;
    else if (setup) prdata <= rd_mux;
  end

  // register writes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_role_select <= io_telemetry_pkg::ROLE_RST;
      standby_policy <= 1'b0;
      local_module_addr <= io_telemetry_pkg::ADDR_RST;
      telemetry_dest_addr <= io_telemetry_pkg::ADDR_RST;
      data_dest_addr <= io_telemetry_pkg::ADDR_RST;
      update_period_ms <= io_telemetry_pkg::PERIOD_RST;
      edge_cfg <= '0;
    end else if (wr_en) begin
      if (hit_ctrl) begin
        io_role_select <= pwdata[io_telemetry_pkg::CTRL_ROLE_LSB +: 2];
        standby_policy <= pwdata[io_telemetry_pkg::CTRL_STANDBY_BIT];
      end
      if (hit_addr) begin
        local_module_addr <= pwdata[io_telemetry_pkg::ADDR_LOCAL_LSB +: 8];
        telemetry_dest_addr <= pwdata[io_telemetry_pkg::ADDR_TEL_LSB +: 8];
        data_dest_addr <= pwdata[io_telemetry_pkg::ADDR_DATA_LSB +: 8];
      end
      if (hit_period) update_period_ms <= pwdata[15:0];
      if (hit_edge) edge_cfg[2*edge_idx +: 2] <= pwdata[1:0];
    end
  end

  // data binding routing for the serial link
  assign serial_orders_en = data_dest_addr == 8'h00;
  assign serial_data_dest = data_dest_addr;

  // millisecond timebase
  assign ms_tick = ms_cnt == 32'(MS_CYCLES - 1);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) ms_cnt <= 32'h0000_0000;
    else ms_cnt <= ms_tick ? 32'h0000_0000 : ms_cnt + 32'h0000_0001;
  end

  // update period, held at the 100 ms floor
  assign period_eff = update_period_ms < io_telemetry_pkg::PERIOD_MIN_MS ?
                      io_telemetry_pkg::PERIOD_MIN_MS : update_period_ms;
  assign period_due = ms_tick && per_cnt >= period_eff - 16'h0001;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) per_cnt <= 16'h0000;
    else if (period_due) per_cnt <= 16'h0000;
    else if (ms_tick) per_cnt <= per_cnt + 16'h0001;
  end

  // edge detection; in standby only the wake inputs are live
  logic [N-1:0] edge_allow;
  logic edge_any;
  always_comb begin
    edge_allow = {N{1'b1}};
    if (standby) begin
      edge_allow = '0;
      edge_allow[io_telemetry_pkg::WAKE_A_IDX] = 1'b1;
      edge_allow[io_telemetry_pkg::WAKE_B_IDX] = 1'b1;
    end
  end
  edge_detect #(.N(N)) u_edge (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_in(io_in),
    .mode_cfg(edge_cfg),
    .allow(edge_allow),
    .edge_any(edge_any)
  );

  // telemetry triggers; the server never sends on its own
  wire edge_send = edge_any & ~is_server;
  wire period_send = period_due & (is_tel_client | (is_client & cstate != ST_WAIT));
  wire tel_trig = edge_send | period_send;
  wire server_rx = rx_valid & is_server;
  wire client_rx = rx_valid & is_client & cstate == ST_WAIT & rx_src == telemetry_dest_addr;

  // frame arbitration: error, then reply, then telemetry
  logic fb_busy;
  wire any_err = |pend_err;
  wire [3:0] err_idx = first_one(pend_err);
  wire fb_start = ~fb_busy & (any_err | pend_reply | pend_tel);
  wire sel_err = any_err;
  wire sel_reply = ~any_err & pend_reply;
  wire sel_tel = ~any_err & ~pend_reply & pend_tel;
  wire [7:0] next_dest = sel_err ? local_module_addr :
                         sel_reply ? reply_dest : telemetry_dest_addr;
  wire next_local = sel_err | (next_dest == local_module_addr);
  wire [15:0] period_s_full = period_eff / 16'(io_telemetry_pkg::MS_PER_S);

  reply_framer u_framer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(fb_start),
    .is_err(sel_err),
    .addr(sel_err ? io_telemetry_pkg::ERR_ADDR : local_module_addr),
    .values(io_in),
    .busy(fb_busy),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data),
    .out_last(tx_last)
  );

  // pending requests; a new trigger wins over the clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_tel <= 1'b0;
      pend_reply <= 1'b0;
      reply_dest <= 8'h00;
    end else begin
      if (tel_trig) pend_tel <= 1'b1;
      else if (fb_start && sel_tel) pend_tel <= 1'b0;
      if (server_rx) begin
        pend_reply <= 1'b1;
        reply_dest <= rx_src;
      end else if (fb_start && sel_reply) pend_reply <= 1'b0;
    end
  end

  // route and period stamp taken when a frame starts
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_dest <= 8'h00;
      tx_local <= 1'b0;
      tx_period_s <= 8'h00;
      ack_tx <= 1'b0;
    end else begin
      ack_tx <= fb_start & sel_err;
      if (fb_start) begin
        tx_dest <= next_dest;
        tx_local <= next_local;
        tx_period_s <= period_s_full[7:0];
      end
    end
  end

  // client sequence: send, wait answer, optionally sleep
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) cstate <= ST_RUN;
    else if (!is_client) cstate <= ST_RUN;
    else begin
      unique case (cstate)
        ST_RUN: if (fb_start && sel_tel) cstate <= ST_WAIT;
        ST_WAIT: begin
          if (client_rx) cstate <= standby_policy ? ST_SLEEP : ST_RUN;
          else if (period_due) cstate <= ST_RUN;
        end
        ST_SLEEP: if (tel_trig) cstate <= ST_RUN;
        default: cstate <= ST_RUN;
      endcase
    end
  end
  assign standby = cstate == ST_SLEEP;

  // outputs follow the partner's input values
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) io_out <= '0;
    else if (client_rx || server_rx) io_out <= rx_values;
  end

  // supervision slot table, first clients to speak take slots
  wire [3:0] free_idx = first_one(~slot_used);
  wire rx_known = |slot_match;
  genvar s;
  generate
    for (s = 0; s < SLOTS; s++) begin : g_slot
      wire [19:0] limit = 20'(slot_per[s]) * 20'(2 * io_telemetry_pkg::MS_PER_S)
                          + io_telemetry_pkg::GRACE_MS;
      wire take = server_rx & ~rx_known & free_idx == 4'(s);
      assign slot_match[s] = slot_used[s] & slot_addr[s] == rx_src;
      assign slot_expire[s] = is_server & slot_used[s] & ms_tick & slot_ms[s] >= limit;
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          slot_used[s] <= 1'b0;
          slot_addr[s] <= 8'h00;
          slot_per[s] <= 8'h00;
          slot_ms[s] <= 20'h0_0000;
        end else if (!is_server) begin
          slot_used[s] <= 1'b0;
        end else if (take || (server_rx && slot_match[s])) begin
          slot_used[s] <= 1'b1;
          slot_addr[s] <= rx_src;
          slot_per[s] <= rx_period_s;
          slot_ms[s] <= 20'h0_0000;
        end else if (slot_expire[s]) begin
          slot_ms[s] <= 20'h0_0000;
        end else if (ms_tick && slot_used[s]) begin
          slot_ms[s] <= slot_ms[s] + 20'h0_0001;
        end
      end
      // one error report per expiry; expiry wins over the clear
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) pend_err[s] <= 1'b0;
        else if (slot_expire[s]) pend_err[s] <= 1'b1;
        else if (fb_start && sel_err && err_idx == 4'(s)) pend_err[s] <= 1'b0;
      end
    end
  endgenerate
endmodule : io_telemetry_copy_engine

// ==== dv/engine_checker_assertions.sv ====
// concurrent checks on the telemetry engine ports
`timescale 1ns/100ps
module engine_checker #(
  parameter int N = 9
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  // copy outputs
  input wire logic rx_valid,
  input wire logic [N-1:0] io_out,
  // frame stream
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  // serial side
  input wire logic ack_tx,
  input wire logic serial_orders_en,
  input wire logic [7:0] serial_data_dest
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [3:0] pos;
  // byte position inside the frame being sent
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) pos <= 4'h0;
    else if (tx_valid && tx_ready) pos <= tx_last ? 4'h0 : pos + 4'h1;
  end
  slverr_phase_a: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access phase");
  orders_bind_a: assert property (serial_orders_en == (serial_data_dest == 8'h00))
    else $error("serial orders enable wrong for data destination");
  byte_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("frame byte dropped while stalled");
  sep_byte_a: assert property (tx_valid && pos == 4'h1 |-> tx_data == 8'h54)
    else $error("separator byte wrong");
  tech_byte_a: assert property (tx_valid && pos == 4'h2 |-> tx_data == 8'h44)
    else $error("technology byte wrong");
  kind_byte_a: assert property (tx_valid && pos == 4'h3 |-> tx_data inside {8'h52, 8'h45})
    else $error("reply kind byte wrong");
  err_end_a: assert property (tx_valid && tx_ready && pos == 4'h3 && tx_data == 8'h45
    |=> tx_valid && tx_last && tx_data == 8'h0d)
    else $error("error frame not closed at once");
  cr_last_a: assert property (tx_valid && tx_last |-> tx_data == 8'h0d)
    else $error("last byte is not carriage return");
  ack_single_a: assert property (ack_tx |=> !ack_tx)
    else $error("ack pulse longer than one cycle");
  out_hold_a: assert property (!rx_valid |=> $stable(io_out))
    else $error("outputs changed without a copy frame");
endmodule : engine_checker

bind io_telemetry_copy_engine engine_checker #(.N(N)) i_engine_checker (
  .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pslverr(pslverr),
  .rx_valid(rx_valid), .io_out(io_out), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_data(tx_data), .tx_last(tx_last), .ack_tx(ack_tx),
  .serial_orders_en(serial_orders_en), .serial_data_dest(serial_data_dest)
);

// ==== dv/link_partner.sv ====
// far-side model: frame byte sink and copy frame source
`timescale 1ns/100ps
module link_partner (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // byte sink
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic slow,
  // copy frame source
  output logic rx_valid = 1'b0,
  output logic [7:0] rx_src = 8'h00,
  output logic [7:0] rx_period_s = 8'h00,
  output logic [8:0] rx_values = 9'h000
);
  logic [7:0] last[$];
  logic [7:0] cur[$];
  int nframes = 0;
  // take bytes, stalling every other cycle when slow
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
      if (tx_valid && tx_ready) begin
        cur.push_back(tx_data);
        if (tx_last) begin
          last = cur;
          cur.delete();
          nframes++;
        end
      end
    end
  end
  // one update frame with the sender period in seconds
  task automatic send(input logic [7:0] src, input logic [7:0] per, input logic [8:0] val);
    @(posedge core_clk);
    while (tx_valid) @(posedge core_clk); // listen before talk
    rx_valid <= 1'b1;
    rx_src <= src;
    rx_period_s <= per;
    rx_values <= val;
    @(posedge core_clk);
    rx_valid <= 1'b0;
    rx_src <= ~src;
    rx_period_s <= ~per;
    rx_values <= ~val;
  endtask : send
endmodule : link_partner

// ==== dv/testbench.sv ====
// self-checking bench for the telemetry and copy engine
`timescale 1ns/100ps
module testbench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, rx_valid, tx_valid, tx_ready, tx_last, tx_local;
  logic ack_tx, serial_orders_en, standby;
  logic slow = 1'b1;
  logic [8:0] io_in = 9'h100;
  logic [8:0] io_out, rx_values;
  logic [7:0] rx_src, rx_period_s, tx_data, tx_dest, tx_period_s, serial_data_dest;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  int n0, t0, k, m;
  // clock and cycle count
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  io_telemetry_copy_engine #(.MS_CYCLES(4)) i_io_telemetry_copy_engine (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .io_in(io_in), .io_out(io_out), .rx_valid(rx_valid), .rx_src(rx_src),
    .rx_period_s(rx_period_s), .rx_values(rx_values), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last), .tx_dest(tx_dest),
    .tx_local(tx_local), .tx_period_s(tx_period_s), .ack_tx(ack_tx),
    .serial_orders_en(serial_orders_en), .serial_data_dest(serial_data_dest),
    .standby(standby)
  );
  link_partner i_link_partner (
    .core_clk(core_clk), .rst_n(rst_n), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .tx_last(tx_last), .slow(slow), .rx_valid(rx_valid),
    .rx_src(rx_src), .rx_period_s(rx_period_s), .rx_values(rx_values)
  );
  task automatic stop_test();
    if (err_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // one apb transfer; read data and error taken at the ready edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check("apb wait states", n, 32'h0000_0001);
  endtask : apb
  task automatic wait_frames(input int n, input int lim);
    for (k = 0; k < lim && i_link_partner.nframes < n; k++) @(posedge core_clk);
    check("frame count", i_link_partner.nframes, n);
  endtask : wait_frames
  task automatic chk_frame(input logic [7:0] e[7], input int len);
    check("frame length", i_link_partner.last.size(), len);
    for (int i = 0; i < len; i++) check("frame byte", i_link_partner.last[i], e[i]);
  endtask : chk_frame
  // watchdog
  initial begin
    repeat (60000) @(posedge core_clk);
    err_count++;
    stop_test();
  end
  // main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    apb(1'b0, io_telemetry_pkg::OFS_PERIOD, 0); check("period reset", rd, 32'h0000_03e8);
    apb(1'b0, io_telemetry_pkg::OFS_CTRL, 0); check("ctrl reset", rd, 32'h0000_0000);
    apb(1'b0, 8'h30, 0); check("unmapped error", er, 1'b1);
    apb(1'b1, io_telemetry_pkg::OFS_ADDR, 32'h0000_0f0f);
    apb(1'b1, 8'h48, 32'h0000_0003);
    apb(1'b0, 8'h48, 0); check("edge mode read", rd, 32'h0000_0003);
    // rise, fall and both on input 0 with a stalling sink
    for (m = 1; m < 4; m++) begin
      apb(1'b1, io_telemetry_pkg::OFS_EDGE_BASE, m);
      n0 = i_link_partner.nframes;
      io_in[0] <= 1'b1;
      repeat (40) @(posedge core_clk);
      check("frames after rise", i_link_partner.nframes - n0, m & 1);
      io_in[0] <= 1'b0;
      repeat (40) @(posedge core_clk);
      check("frames after fall", i_link_partner.nframes - n0, (m & 1) + (m >> 1));
    end
    chk_frame('{8'h0f, 8'h54, 8'h44, 8'h52, 8'h01, 8'h00, 8'h0d}, 7);
    check("local route", tx_local, 1'b1);
    check("local dest", tx_dest, 8'h0f);
    check("period stamp", tx_period_s, 8'h01);
    // data binding beside telemetry binding
    apb(1'b1, io_telemetry_pkg::OFS_ADDR, 32'h0033_200f);
    @(posedge core_clk);
    check("orders off", serial_orders_en, 1'b0);
    check("data dest", serial_data_dest, 8'h33);
    // server: no own edge frames, answers clients, supervises them
    apb(1'b1, io_telemetry_pkg::OFS_CTRL, 32'h0000_0001);
    slow <= 1'b0;
    n0 = i_link_partner.nframes;
    io_in[0] <= 1'b1;
    repeat (40) @(posedge core_clk);
    check("server silent", i_link_partner.nframes, n0);
    i_link_partner.send(8'h21, 8'h01, 9'h0a5);
    wait_frames(n0 + 1, 50);
    t0 = cyc;
    check("server outputs", io_out, 9'h0a5);
    check("reply dest", tx_dest, 8'h21);
    chk_frame('{8'h0f, 8'h54, 8'h44, 8'h52, 8'h01, 8'h01, 8'h0d}, 7);
    for (k = 0; k < 14000 && !ack_tx; k++) @(posedge core_clk);
    check("timeout span", (cyc - t0) inside {[11900:12100]}, 1'b1);
    wait_frames(n0 + 2, 50);
    chk_frame('{8'hff, 8'h54, 8'h44, 8'h45, 8'h0d, 8'h00, 8'h00}, 5);
    repeat (11000) @(posedge core_clk);
    check("one report", i_link_partner.nframes, n0 + 2);
    apb(1'b0, io_telemetry_pkg::OFS_SLOTS, 0); check("slot table", rd, 32'h0000_0001);
    // telemetry client at the minimum period
    apb(1'b1, io_telemetry_pkg::OFS_PERIOD, 32'h0000_0032);
    apb(1'b1, io_telemetry_pkg::OFS_CTRL, 32'h0000_0003);
    wait_frames(i_link_partner.nframes + 1, 1000);
    t0 = cyc;
    wait_frames(i_link_partner.nframes + 1, 1000);
    check("period gap", (cyc - t0) inside {[398:402]}, 1'b1);
    check("telemetry dest", tx_dest, 8'h20);
    check("remote route", tx_local, 1'b0);
    // copy client with standby between updates
    apb(1'b1, io_telemetry_pkg::OFS_CTRL, 32'h0000_0006);
    wait_frames(i_link_partner.nframes + 1, 1000);
    i_link_partner.send(8'h20, 8'h00, 9'h15a);
    repeat (10) @(posedge core_clk);
    check("client outputs", io_out, 9'h15a);
    check("client sleeps", standby, 1'b1);
    n0 = i_link_partner.nframes;
    io_in[0] <= 1'b0;
    repeat (40) @(posedge core_clk);
    check("plain input asleep", i_link_partner.nframes, n0);
    io_in[2] <= 1'b1;
    wait_frames(n0 + 1, 60);
    stop_test();
  end
endmodule : testbench
